// file: wsw_watchdog_sleep.v
// Watchdog timer with sleep entry and wake-up control behind an APB slave
// What this block does
// - Watchdog counts on its own RC oscillator tick, also during sleep.
// - Time-out while running gives a full internal device reset.
// - Time-out while asleep wakes the device and execution resumes.
// - Enable fuse bit 2 of configuration word clear disables the watchdog.
// - Without prescaler the time-out is nominally 18 ms of watchdog clock.
// - Option register can assign the prescaler, dividing up to 1:128.
// - Kick or sleep clears counter and assigned prescaler.
// - Any watchdog time-out clears the active-low expired flag.
// - Sleep clears watchdog, clears power-down flag, sets expired flag, stops oscillator.
// - Pins hold their pre-sleep drive state while asleep.
// - Watchdog reset never drives the master clear pin low.
// - Sleep exits on master clear, watchdog, or enabled interrupt sources.
// - Power-down flag set at power-up, cleared by sleep.
// - Only individual enables gate wake; global enable is ignored.
// - Interrupt wake runs next instruction, then vectors 0004h if global enabled.
// - Pending enabled interrupt at sleep wakes at once after sleep completes.
// - Every wake-up clears the watchdog counter.
// - Crystal modes wait 1024 oscillator periods on wake; RC mode does not.
// - Global enable is bit 7 of the interrupt control register.
`timescale 1ns/1ps
`default_nettype none
`include "wsw_consts.vh"
module wsw_watchdog_sleep #(
  parameter [15:0] WDT_TICKS = `WSW_WDT_BASE_TICKS,
  parameter [10:0] OST_CYCLES = `WSW_OST_TOSC
) (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [17:0] paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        wdtOscTick,
  input  wire        kickInstruction,
  input  wire        sleepInstruction,
  input  wire        edgeIrqFlag,
  input  wire        portChangeFlag,
  input  wire        comparatorFlag,
  input  wire        masterClearPinN,
  input  wire [12:0] pinOutCore,
  input  wire [12:0] pinOeCore,
  output reg  [12:0] pinOut,
  output reg  [12:0] pinOe,
  output reg         deviceReset,
  output reg         oscDriverOn,
  output reg         coreRun,
  output reg         wakePulse,
  output reg         vectorBranch,
  output reg  [12:0] vectorAddr,
  output reg         asleep
);

  localparam [1:0] ST_RUN   = 2'h0;
  localparam [1:0] ST_SLEEP = 2'h1;
  localparam [1:0] ST_OST   = 2'h2;

  // Two-flop synchronisers for the pin-side inputs
  reg [1:0] tickSync_q;
  reg [1:0] mclrSync_q;
  reg       tickSeen_q;
  wire      tickRise = tickSync_q[1] & ~tickSeen_q;

  reg [7:0]  optionCtl_q;
  reg [7:0]  configWord_q;
  reg [7:0]  irqControlReg_q;
  reg [2:0]  wakeEnable_q;
  reg        dogExpiredN_q;
  reg        powerDownN_q;
  reg [15:0] watchdogCounter_q;
  reg [6:0]  prescale_q;
  reg [1:0]  state_q;
  reg [10:0] ostCount_q;
  reg        vectorPend_q;

  wire watchdogEnableFuse = configWord_q[`WSW_CFG_WDTEN];
  wire prescalerAssign    = optionCtl_q[`WSW_OPT_PSA];
  wire [2:0] prescaleRatio = optionCtl_q[2:0];
  wire globalIrqAllow     = irqControlReg_q[`WSW_IC_GIE];
  wire rcMode = (configWord_q[`WSW_CFG_OSC_HI:`WSW_CFG_OSC_LO] == `WSW_OSC_RC);

  // Pending source gated by its own enable only, never by global enable
  wire irqWake = (edgeIrqFlag & wakeEnable_q[`WSW_CT_INTE]) |
                 (portChangeFlag & wakeEnable_q[`WSW_CT_RBIE]) |
                 (comparatorFlag & wakeEnable_q[`WSW_CT_CMIE]);

  function prescaleDone;
    input [6:0] cnt;
    input [2:0] ratio;
    begin
      prescaleDone = (cnt == ((7'h01 << ratio) - 7'h01));
    end
  endfunction

  // Address decode shared by the write path and the error response
  function addrMapped;
    input [17:0] a;
    begin
      addrMapped = (a == `WSW_ADDR_OPTION) || (a == `WSW_ADDR_CONFIG) ||
                   (a == `WSW_ADDR_IRQCTL) || (a == `WSW_ADDR_CTRL) ||
                   (a == `WSW_ADDR_STATUS);
    end
  endfunction

  // Watchdog wake never vectors, only an interrupt wake with global enable
  wire vectorWake = irqWake & ~timeOut & globalIrqAllow;

  wire baseDone = (watchdogCounter_q == WDT_TICKS - 16'h0001);
  wire postDone = ~prescalerAssign | prescaleDone(prescale_q, prescaleRatio);
  wire timeOut  = watchdogEnableFuse & tickRise & baseDone & postDone;

  wire apbWrite = psel & penable & pwrite;
  wire clearDog = kickInstruction | (sleepInstruction & state_q == ST_RUN);
  wire wakeNow  = (state_q == ST_SLEEP) & (timeOut | irqWake);

  // RC tick crosses in through two flops before the edge detect reads it
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      tickSync_q <= 2'h0;
    end else begin
      tickSync_q <= {tickSync_q[0], wdtOscTick};
    end
  end

  // Idle level of the tick is low, so no false edge follows reset
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      tickSeen_q <= 1'b0;
    end else begin
      tickSeen_q <= tickSync_q[1];
    end
  end

  // Master clear idles high; reset to high avoids a spurious clear
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      mclrSync_q <= 2'h3;
    end else begin
      mclrSync_q <= {mclrSync_q[0], masterClearPinN};
    end
  end

  // Watchdog counter and prescaler
  always @(posedge clk_sys) begin
    if (!rst_n || !mclrSync_q[1]) begin
      watchdogCounter_q <= 16'h0000;
      prescale_q <= 7'h00;
    end else if (clearDog || wakeNow || timeOut) begin
      watchdogCounter_q <= 16'h0000;
      prescale_q <= 7'h00;
    end else if (watchdogEnableFuse && tickRise) begin
      // Counter keeps running in sleep: it only needs the RC tick
      if (baseDone) begin
        watchdogCounter_q <= 16'h0000;
        prescale_q <= prescale_q + 7'h01;
      end else begin
        watchdogCounter_q <= watchdogCounter_q + 16'h0001;
      end
    end
  end

  // Status flags: a time-out in the same cycle as a kick still counts
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      dogExpiredN_q <= 1'b1;
      powerDownN_q <= 1'b1;
    end else if (!mclrSync_q[1]) begin
      dogExpiredN_q <= 1'b1;
    end else begin
      if (timeOut)
        dogExpiredN_q <= 1'b0;
      else if (clearDog)
        dogExpiredN_q <= 1'b1;
      if (sleepInstruction && state_q == ST_RUN && !timeOut)
        powerDownN_q <= 1'b0;
      else if (kickInstruction)
        powerDownN_q <= 1'b1;
    end
  end

  // Sleep state machine
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= ST_RUN;
      ostCount_q <= 11'h000;
      vectorPend_q <= 1'b0;
      oscDriverOn <= 1'b1;
      coreRun <= 1'b1;
      wakePulse <= 1'b0;
      vectorBranch <= 1'b0;
      vectorAddr <= 13'h0000;
      deviceReset <= 1'b0;
      asleep <= 1'b0;
    end else begin
      wakePulse <= 1'b0;
      vectorBranch <= 1'b0;
      vectorAddr <= 13'h0000;
      deviceReset <= 1'b0;
      if (!mclrSync_q[1]) begin
        // External clear always resets, also out of sleep
        state_q <= ST_RUN;
        vectorPend_q <= 1'b0;
        deviceReset <= 1'b1;
        oscDriverOn <= 1'b1;
        coreRun <= 1'b1;
        asleep <= 1'b0;
      end else begin
        case (state_q)
          ST_RUN: begin
            if (timeOut) begin
              deviceReset <= 1'b1;
            end else if (sleepInstruction) begin
              oscDriverOn <= 1'b0;
              coreRun <= 1'b0;
              asleep <= 1'b1;
              state_q <= ST_SLEEP;
            end
          end
          ST_SLEEP: begin
            if (wakeNow) begin
              oscDriverOn <= 1'b1;
              ostCount_q <= 11'h000;
              // Vector decision stays pending until the core resumes
              vectorPend_q <= vectorWake;
              if (rcMode) begin
                state_q <= ST_RUN;
                coreRun <= 1'b1;
                asleep <= 1'b0;
                wakePulse <= 1'b1;
                vectorBranch <= vectorWake;
                vectorAddr <= vectorWake ? `WSW_IRQ_VECTOR : 13'h0000;
              end else begin
                state_q <= ST_OST;
              end
            end
          end
          ST_OST: begin
            // Address shows only with the branch pulse, as the core takes it then
            if (ostCount_q == OST_CYCLES - 11'h001) begin
              state_q <= ST_RUN;
              coreRun <= 1'b1;
              asleep <= 1'b0;
              wakePulse <= 1'b1;
              vectorBranch <= vectorPend_q;
              vectorAddr <= vectorPend_q ? `WSW_IRQ_VECTOR : 13'h0000;
            end else begin
              ostCount_q <= ostCount_q + 11'h001;
            end
          end
          default: state_q <= ST_RUN;
        endcase
      end
    end
  end

  // Pins track the core while awake and freeze while asleep
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pinOut <= 13'h0000;
      pinOe <= 13'h0000;
    end else if (state_q == ST_RUN && !(sleepInstruction)) begin
      pinOut <= pinOutCore;
      pinOe <= pinOeCore;
    end
  end

  // APB register file
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      optionCtl_q <= `WSW_OPT_RST;
      configWord_q <= `WSW_CFG_RST;
      irqControlReg_q <= `WSW_IC_RST;
      wakeEnable_q <= 3'h0;
    end else if (apbWrite && addrMapped(paddr)) begin
      case (paddr)
        `WSW_ADDR_OPTION: optionCtl_q <= pwdata[7:0];
        `WSW_ADDR_CONFIG: configWord_q <= pwdata[7:0];
        `WSW_ADDR_IRQCTL: irqControlReg_q <= pwdata[7:0];
        `WSW_ADDR_CTRL: wakeEnable_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Zero-wait slave: ready in the access cycle, data registered in setup
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        // Unmapped words answer with an error and read as zero
        pslverr <= ~addrMapped(paddr);
        case (paddr)
          `WSW_ADDR_OPTION: prdata <= {24'h000000, optionCtl_q};
          `WSW_ADDR_CONFIG: prdata <= {24'h000000, configWord_q};
          `WSW_ADDR_IRQCTL: prdata <= {24'h000000, irqControlReg_q};
          `WSW_ADDR_CTRL:   prdata <= {29'h00000000, wakeEnable_q};
          `WSW_ADDR_STATUS: prdata <= {27'h0000000, dogExpiredN_q, powerDownN_q, 3'h0};
          default:          ;
        endcase
      end
    end
  end

endmodule // wsw_watchdog_sleep
`default_nettype wire

// file: wsw_consts.vh
// Register offsets, field positions, reset values and timing counts for the watchdog/sleep block
`ifndef WSW_CONSTS_VH
`define WSW_CONSTS_VH
// APB byte addresses: printed 0x81 is not word aligned, so index times four
`define WSW_IDX_OPTION      16'h0081
`define WSW_IDX_CONFIG      16'h2007
`define WSW_IDX_STATUS      16'h0003
`define WSW_IDX_IRQCTL      16'h000b
`define WSW_IDX_CTRL        16'h0010
`define WSW_ADDR_OPTION     18'h00204
`define WSW_ADDR_CONFIG     18'h0801c
`define WSW_ADDR_STATUS     18'h0000c
`define WSW_ADDR_IRQCTL     18'h0002c
`define WSW_ADDR_CTRL       18'h00040
// Option register fields
`define WSW_OPT_PSA         3
`define WSW_OPT_RST         8'hff
// Configuration word fields
`define WSW_CFG_WDTEN       2
`define WSW_CFG_OSC_HI      1
`define WSW_CFG_OSC_LO      0
`define WSW_CFG_RST         8'hff
`define WSW_OSC_RC          2'h3
// Status fields (active-low flags)
`define WSW_ST_TO           4
`define WSW_ST_PD           3
// Interrupt control fields
`define WSW_IC_GIE          7
`define WSW_IC_RST          8'h00
// Control register fields (wake enables)
`define WSW_CT_INTE         0
`define WSW_CT_RBIE         1
`define WSW_CT_CMIE         2
// Timing
`define WSW_WDT_PERIOD_US   18000
`define WSW_WDT_OSC_KHZ     14
`define WSW_WDT_BASE_TICKS  ((`WSW_WDT_PERIOD_US * `WSW_WDT_OSC_KHZ) / 1000)
`define WSW_OST_TOSC        1024
`define WSW_IRQ_VECTOR      13'h0004
`endif

// file: wsw_checker.sv
// Port assertions for the watchdog and sleep block
`timescale 1ns/1ps
`default_nettype none
module wsw_checker #(
  parameter [15:0] WDT_TICKS  = 16'h0004,
  parameter [10:0] OST_CYCLES = 11'h004
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        sleepInstruction,
  input wire logic        masterClearPinN,
  input wire logic        coreRun,
  input wire logic        asleep,
  input wire logic        oscDriverOn,
  input wire logic        deviceReset,
  input wire logic        wakePulse,
  input wire logic        vectorBranch,
  input wire logic [12:0] vectorAddr,
  input wire logic [12:0] pinOut,
  input wire logic [12:0] pinOe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_enter;
    sleepInstruction && coreRun && !asleep;
  endsequence
  sequence s_parked;
    asleep && !oscDriverOn && !coreRun;
  endsequence
  a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
    else $error("access answer wrong");
  a_sleep_entry: assert property (s_enter |=> s_parked)
    else $error("sleep entry incomplete");
  a_osc_stays_off: assert property (asleep && !oscDriverOn |=> oscDriverOn || s_parked)
    else $error("oscillator or core on in sleep");
  a_core_held: assert property (asleep |-> !coreRun)
    else $error("core running in sleep");
  a_pins_frozen: assert property (asleep && $past(asleep) |-> $stable(pinOut) && $stable(pinOe))
    else $error("pins moved in sleep");
  a_vector_pair: assert property (vectorBranch |-> wakePulse && vectorAddr == 13'h0004)
    else $error("vector without wake");
  a_vector_idle: assert property (!vectorBranch |-> vectorAddr == 13'h0000)
    else $error("vector address stray");
  a_wake_resumes: assert property (wakePulse |-> coreRun && !asleep && oscDriverOn)
    else $error("wake without resume");
  a_wake_single: assert property (wakePulse |=> !wakePulse)
    else $error("wake pulse too long");
  a_no_reset_asleep: assert property (masterClearPinN [*5] ##0 asleep |-> !deviceReset)
    else $error("reset while asleep");
endmodule // wsw_checker
bind wsw_watchdog_sleep wsw_checker #(.WDT_TICKS(WDT_TICKS), .OST_CYCLES(OST_CYCLES)) wsw_checker_i (
  .clk_sys, .rst_n, .psel, .penable, .pready, .sleepInstruction, .masterClearPinN, .coreRun,
  .asleep, .oscDriverOn, .deviceReset, .wakePulse, .vectorBranch, .vectorAddr, .pinOut, .pinOe);
`default_nettype wire

// file: wsw_core_model.sv
// Core-side model: instruction pulses, interrupt flags, pin drive, watchdog RC clock
`timescale 1ns/1ps
`default_nettype none
module wsw_core_model (
  input  wire logic        clk_sys,
  output var  logic        wdtOscTick,
  output var  logic        kickInstruction,
  output var  logic        sleepInstruction,
  output var  logic [2:0]  irqFlags,
  output var  logic [12:0] pinOutCore,
  output var  logic [12:0] pinOeCore
);
  int tickCount = 0;
  initial begin
    wdtOscTick = 1'b0;
    kickInstruction = 1'b0;
    sleepInstruction = 1'b0;
    irqFlags = 3'h0;
    pinOutCore = 13'h0000;
    pinOeCore = 13'h0000;
  end
  // Free RC clock, phase unrelated to clk_sys
  always #137 wdtOscTick = ~wdtOscTick;
  always @(posedge wdtOscTick) tickCount++;
  // Pins keep moving so that a frozen output means something
  always @(posedge clk_sys) begin
    pinOutCore <= 13'($urandom);
    pinOeCore  <= 13'($urandom);
  end
  task automatic issue(input bit slp);
    @(posedge clk_sys);
    sleepInstruction <= slp;
    kickInstruction  <= !slp;
    @(posedge clk_sys);
    sleepInstruction <= 1'b0;
    kickInstruction  <= 1'b0;
  endtask
  task automatic setIrq(input logic [2:0] v);
    irqFlags <= v;
  endtask
endmodule // wsw_core_model
`default_nettype wire

// file: wsw_watchdog_sleep_bench.sv
// Self-checking bench for the watchdog and sleep block
`timescale 1ns/1ps
`default_nettype none
`include "wsw_consts.vh"
module wsw_watchdog_sleep_bench;
  localparam int TK = 4;
  localparam int OS = 4;
  logic        clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, masterClearPinN = 1;
  logic        pready, pslverr, err, wdtOscTick, kickInstruction, sleepInstruction;
  logic        deviceReset, oscDriverOn, coreRun, wakePulse, vectorBranch, asleep;
  logic [2:0]  irqFlags;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [12:0] pinOutCore, pinOeCore, pinOut, pinOe, vectorAddr, pk;
  int          fails = 0, num_checks = 0, n, c, t0, ex, rstCnt = 0, r;
  wsw_watchdog_sleep #(.WDT_TICKS(16'(TK)), .OST_CYCLES(11'(OS))) wsw_watchdog_sleep_i (
    .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .wdtOscTick, .kickInstruction, .sleepInstruction, .edgeIrqFlag(irqFlags[0]),
    .portChangeFlag(irqFlags[1]), .comparatorFlag(irqFlags[2]), .masterClearPinN, .pinOutCore,
    .pinOeCore, .pinOut, .pinOe, .deviceReset, .oscDriverOn, .coreRun, .wakePulse, .vectorBranch,
    .vectorAddr, .asleep);
  wsw_core_model core_i (.clk_sys, .wdtOscTick, .kickInstruction, .sleepInstruction, .irqFlags,
    .pinOutCore, .pinOeCore);
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (deviceReset === 1'b1) rstCnt++;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input bit wr, input logic [17:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdchk(input logic [17:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(0, a, 0);
    check("reg_read", rd & 32'(m), 32'(e));
  endtask
  task automatic waitFor(input int lim, input bit wake);
    n = 0;
    while ((wake ? wakePulse : deviceReset) !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #1500us;
    fails++;
    end_sim();
  end
  initial begin
    void'($urandom(65728));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    rdchk(`WSW_ADDR_OPTION, 8'hff, 8'hff);
    rdchk(`WSW_ADDR_CONFIG, 8'hff, 8'hff);
    rdchk(`WSW_ADDR_STATUS, 8'h18, 8'h18);
    rdchk(`WSW_ADDR_IRQCTL, 8'hff, 8'h00);
    apb(0, 18'h3ff00, 0);
    check("unmapped_err", err, 1);
    $display("test registers done");
    // Time-out length, unassigned then prescaled up to the 1:128 corner
    for (int i = 0; i < 4; i++) begin
      r = (i == 3) ? 7 : $urandom_range(0, 6);
      apb(1, `WSW_ADDR_OPTION, (i == 0) ? 32'h0 : 32'(8 + r));
      core_i.issue(0);
      t0 = core_i.tickCount;
      ex = (i == 0) ? TK : TK << r;
      waitFor(20000, 0);
      t0 = core_i.tickCount - t0;
      check("period", t0 >= ex - 1 && t0 <= ex + 1, 1);
      repeat (3) @(posedge clk_sys);
      rdchk(`WSW_ADDR_STATUS, 8'h10, 8'h00);
    end
    $display("test period done");
    apb(1, `WSW_ADDR_OPTION, 0);
    c = rstCnt;
    repeat (30) begin
      core_i.issue(0);
      repeat (16) @(posedge clk_sys);
    end
    check("kick_holds", rstCnt - c, 0);
    apb(1, `WSW_ADDR_CONFIG, 8'hfb);
    c = rstCnt;
    repeat (400) @(posedge clk_sys);
    check("fuse_off", rstCnt - c, 0);
    apb(1, `WSW_ADDR_CONFIG, 8'hff);
    core_i.issue(1);
    c = rstCnt;
    rdchk(`WSW_ADDR_STATUS, 8'h18, 8'h10);
    waitFor(300, 1);
    check("dog_wake", {vectorBranch, 31'(rstCnt - c)}, 0);
    rdchk(`WSW_ADDR_STATUS, 8'h10, 8'h00);
    $display("test watchdog done");
    apb(1, `WSW_ADDR_OPTION, 8'h0f);
    for (int s = 0; s < 7; s++) begin
      apb(1, `WSW_ADDR_CTRL, 32'(1 << (s % 3)));
      apb(1, `WSW_ADDR_IRQCTL, (s > 2) ? 32'h80 : 32'h0);
      apb(1, `WSW_ADDR_CONFIG, (s == 5) ? 8'hfc : 8'hff);
      core_i.setIrq(3'((s == 6) ? (1 << (s % 3)) : (1 << ((s + 1) % 3))));
      core_i.issue(1);
      if (s == 6) begin
        waitFor(20, 1);
        check("pending_wake", n < 20, 1);
      end else begin
        @(posedge clk_sys);
        pk = pinOut;
        repeat (10) @(posedge clk_sys);
        check("masked_stays", {asleep, pinOut}, {1'b1, pk});
        core_i.setIrq(3'(1 << (s % 3)));
        waitFor(200, 1);
        check("wake_delay", (s == 5) ? (n >= OS + 1 && n <= OS + 3) : n, (s == 5) ? 1 : 2);
        check("vector", {vectorBranch, vectorAddr}, (s > 2) ? 14'h2004 : 14'h0);
      end
      core_i.setIrq(0);
      repeat (2) @(posedge clk_sys);
    end
    $display("test interrupt wake done");
    core_i.issue(1);
    masterClearPinN <= 0;
    repeat (6) @(posedge clk_sys);
    check("master_clear_pin_n_reset", deviceReset, 1);
    masterClearPinN <= 1;
    repeat (6) @(posedge clk_sys);
    check("master_clear_pin_n_awake", asleep, 0);
    $display("test master clear done");
    end_sim();
  end
endmodule // wsw_watchdog_sleep_bench
`default_nettype wire
